/* File: vdsp_regs.svh */
`ifndef VDSP_REGS_SVH
`define VDSP_REGS_SVH

// axi-lite register byte offsets
`define VDSP_OFF_CMD_PTR     12'h000
`define VDSP_OFF_LIST_STAT   12'h004
`define VDSP_OFF_ABORT       12'h008
`define VDSP_OFF_EXT_HOLD    12'h00C
`define VDSP_OFF_INT_STAT    12'h010
`define VDSP_OFF_INT_MASK    12'h014
`define VDSP_OFF_NMI_STAT    12'h018
`define VDSP_OFF_CMD_INJECT  12'h01C
// host window onto dsp ram
`define VDSP_RAM_BASE        32'hFFFE0000
`define VDSP_RAM_WORDS       2048
`define VDSP_RAM_LAST        11'h7FF
// field positions
`define VDSP_BIT_RUN         0
`define VDSP_BIT_HALT        0
`define VDSP_BIT_ERR         0
`define VDSP_BIT_UND         1
`define VDSP_BIT_EXTHOLD     0
// command word layout
`define VDSP_OPC_MSB         15
`define VDSP_OPC_LSB         11
`define VDSP_ARG_MSB         10
// reset values
`define VDSP_RST_MASK        1'b0
`define VDSP_RST_EXTHOLD     1'b0

`endif

/* File: vdsp_pkg.sv */
package vdsp_pkg;
	typedef enum logic [2:0] {
		VDSP_IDLE  = 3'b000,
		VDSP_FETCH = 3'b001,
		VDSP_EXEC  = 3'b011,
		VDSP_HREQ  = 3'b010,
		VDSP_XFER  = 3'b110,
		VDSP_GAP   = 3'b111
	} vdsp_state_t;

	typedef enum logic [4:0] {
		VDSP_OP_NOP   = 5'h00,
		VDSP_OP_HALT  = 5'h01,
		VDSP_OP_BRK   = 5'h02,
		VDSP_OP_EXTRD = 5'h03,
		VDSP_OP_EXTWR = 5'h04
	} vdsp_op_t;
endpackage

/* File: vdsp_hold_if.sv */
`timescale 1ns/10ps
interface vdsp_hold_if;
	logic	req;
	logic	ack;
	logic	xfer_done;
	modport seq (output req, input ack, input xfer_done);
	modport arb (input req, output ack, output xfer_done);
endinterface

/* File: vdsp_sync3.sv */
`timescale 1ns/10ps
module vdsp_sync3 (
	// clock and reset
	input	wire logic	aclk,
	input	wire logic	aresetn,
	// pin
	input	wire logic	pin_in,
	output	logic		pin_out
);
	logic	s1_r, s2_r, s3_r, out_r;
	logic	out_nxt;
	always_comb begin
		out_nxt = (s2_r == s3_r) ? s2_r : out_r;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			out_r <= 1'b0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= out_nxt;
		end
	end
	assign pin_out = out_r;
endmodule // vdsp_sync3

/* File: vdsp_bus_gate.sv */
`timescale 1ns/10ps
module vdsp_bus_gate (
	// clock and reset
	input	wire logic	aclk,
	input	wire logic	aresetn,
	// core side
	input	wire logic	ext_hold_sync,
	output	logic		hold_ack_out,
	output	logic		bus_done,
	// sequencer side
	vdsp_hold_if.arb	hif
);
	// external hold beats the dsp; one-cycle transaction then release
	logic	grant_r, grant_nxt;
	always_comb begin
		grant_nxt = hif.req && !ext_hold_sync && !grant_r;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			grant_r <= 1'b0;
		else
			grant_r <= grant_nxt;
	end
	assign hif.ack       = grant_r;
	assign hif.xfer_done = grant_r;
	assign hold_ack_out  = grant_r;
	assign bus_done      = grant_r;
endmodule // vdsp_bus_gate

/* File: vdsp_core_if.sv */
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "vdsp_regs.svh"
module vdsp_core_if
	import vdsp_pkg::*;
(
	// clock and reset
	input	wire logic		aclk,
	input	wire logic		aresetn,
	// axi4-lite write address and data
	input	wire logic [31:0]	s_axi_awaddr,
	input	wire logic		s_axi_awvalid,
	output	logic			s_axi_awready,
	input	wire logic [31:0]	s_axi_wdata,
	input	wire logic [3:0]	s_axi_wstrb,
	input	wire logic		s_axi_wvalid,
	output	logic			s_axi_wready,
	output	logic [1:0]		s_axi_bresp,
	output	logic			s_axi_bvalid,
	input	wire logic		s_axi_bready,
	// axi4-lite read
	input	wire logic [31:0]	s_axi_araddr,
	input	wire logic		s_axi_arvalid,
	output	logic			s_axi_arready,
	output	logic [31:0]		s_axi_rdata,
	output	logic [1:0]		s_axi_rresp,
	output	logic			s_axi_rvalid,
	input	wire logic		s_axi_rready,
	// bus arbitration with the core
	input	wire logic		ext_hold_n,
	output	logic			dsp_hold_req,
	output	logic			dsp_hold_ack,
	output	logic			dsp_ext_wr,
	output	logic [10:0]		dsp_ext_arg,
	// interrupts to the core
	output	logic			dsp_irq_out_n,
	output	logic			nmi_req
);
	logic [15:0]	ram [0:`VDSP_RAM_WORDS-1];
	logic		ext_hold_sync, bus_done, gate_ack;
	vdsp_hold_if	hif ();

	vdsp_sync3 u_sync (
		.aclk	(aclk),
		.aresetn(aresetn),
		.pin_in	(~ext_hold_n),
		.pin_out(ext_hold_sync)
	);
	vdsp_bus_gate u_gate (
		.aclk		(aclk),
		.aresetn	(aresetn),
		.ext_hold_sync	(ext_hold_sync),
		.hold_ack_out	(gate_ack),
		.bus_done	(bus_done),
		.hif		(hif)
	);

	// ---- axi write: accept address and data in any order
	logic		aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt;
	logic [31:0]	awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
	logic [3:0]	wstrb_r, wstrb_nxt;
	logic		wr_go;
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready  = !w_have_r && !bvalid_r;
	assign wr_go         = aw_have_r && w_have_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = 2'h0;
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
		end else if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			awaddr_r  <= 32'h0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			bvalid_r  <= bvalid_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
		end
	end

	// ---- address decode, shared by both paths
	function automatic logic in_ram(input logic [31:0] a);
		in_ram = (a[31:12] == `VDSP_RAM_BASE >> 12);
	endfunction
	function automatic logic exempt(input logic [31:0] a);
		exempt = !in_ram(a) && (a[11:0] != `VDSP_OFF_CMD_PTR)
			&& (a[11:0] != `VDSP_OFF_CMD_INJECT);
	endfunction
	logic		run_r, run_nxt;
	logic		wr_ram, wr_viol, rd_go, rd_viol;
	assign wr_ram  = wr_go && in_ram(awaddr_r) && !run_r;
	assign wr_viol = wr_go && run_r && !exempt(awaddr_r);
	assign rd_go   = s_axi_arvalid && s_axi_arready;
	assign rd_viol = rd_go && run_r && !exempt(s_axi_araddr);

	// ---- ram: host byte lanes map low byte to even address, zero waits
	logic [10:0]	hw_word;
	logic [15:0]	fetch_q;
	logic [10:0]	pc_r, pc_nxt;
	assign hw_word = awaddr_r[11:1];
	always_ff @(posedge aclk) begin
		if (wr_ram) begin
			if (wstrb_r[0]) ram[hw_word][7:0] <= wdata_r[7:0];
			if (wstrb_r[1]) ram[hw_word][15:8] <= wdata_r[15:8];
			if (wstrb_r[2]) ram[hw_word + 11'd1][7:0] <= wdata_r[23:16];
			if (wstrb_r[3]) ram[hw_word + 11'd1][15:8] <= wdata_r[31:24];
		end
		fetch_q <= ram[pc_r]; // no reset on the array
	end

	// ---- control registers
	logic		halt_st_r, halt_st_nxt, mask_r, mask_nxt, freeze_r, freeze_nxt;
	logic		err_r, err_nxt, und_r, und_nxt, nmi_r, nmi_nxt;
	logic [15:0]	inject_r, inject_nxt;
	vdsp_state_t	st_r, st_nxt;
	logic		stop, start, wreg;
	logic [4:0]	opc;
	assign wreg  = wr_go && !in_ram(awaddr_r);
	assign start = wreg && !run_r && awaddr_r[11:0] == `VDSP_OFF_CMD_PTR;
	assign opc   = fetch_q[`VDSP_OPC_MSB:`VDSP_OPC_LSB];
	always_comb begin
		run_nxt     = run_r;
		pc_nxt      = pc_r;
		st_nxt      = st_r;
		halt_st_nxt = halt_st_r;
		mask_nxt    = mask_r;
		freeze_nxt  = freeze_r;
		err_nxt     = err_r;
		und_nxt     = und_r;
		nmi_nxt     = 1'b0;
		stop        = 1'b0;
		// keep the command word steady through a long hold wait
		inject_nxt  = (st_r == VDSP_EXEC) ? fetch_q : inject_r;
		if (wreg) begin
			case (awaddr_r[11:0])
			`VDSP_OFF_INT_MASK: mask_nxt = wdata_r[`VDSP_BIT_HALT];
			`VDSP_OFF_EXT_HOLD: freeze_nxt = wdata_r[`VDSP_BIT_EXTHOLD];
			// write one to clear status
			`VDSP_OFF_INT_STAT: if (wdata_r[`VDSP_BIT_HALT]) halt_st_nxt = 1'b0;
			`VDSP_OFF_NMI_STAT: begin
				if (wdata_r[`VDSP_BIT_ERR]) err_nxt = 1'b0;
				if (wdata_r[`VDSP_BIT_UND]) und_nxt = 1'b0;
			end
			default: ;
			endcase
		end
		case (st_r)
		VDSP_IDLE: if (start) begin
			pc_nxt  = wdata_r[`VDSP_ARG_MSB:0];
			run_nxt = 1'b1;
			st_nxt  = VDSP_FETCH;
		end
		VDSP_FETCH: st_nxt = VDSP_EXEC;
		VDSP_EXEC: begin
			pc_nxt = pc_r + 11'd1;
			case (opc)
			VDSP_OP_NOP: st_nxt = VDSP_FETCH;
			VDSP_OP_HALT, VDSP_OP_BRK: stop = 1'b1;
			VDSP_OP_EXTRD, VDSP_OP_EXTWR: st_nxt = VDSP_HREQ;
			default: begin
				stop    = 1'b1;
				und_nxt = 1'b1;
				nmi_nxt = 1'b1;
			end
			endcase
		end
		// parked here while frozen; request only once unfrozen
		VDSP_HREQ: if (hif.ack && hif.req) st_nxt = VDSP_XFER;
		VDSP_XFER: st_nxt = VDSP_GAP; // bus idle for one cycle
		VDSP_GAP: st_nxt = VDSP_FETCH;
		default: st_nxt = VDSP_IDLE;
		endcase
		if (wreg && run_r && awaddr_r[11:0] == `VDSP_OFF_ABORT)
			stop = 1'b1;
		if (wr_viol || rd_viol) begin
			stop    = 1'b1;
			err_nxt = 1'b1;
			nmi_nxt = 1'b1;
		end
		if (stop && run_r) begin
			run_nxt     = 1'b0;
			halt_st_nxt = 1'b1;
			st_nxt      = VDSP_IDLE;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r     <= 1'b0;
			pc_r      <= 11'h0;
			st_r      <= VDSP_IDLE;
			halt_st_r <= 1'b0;
			mask_r    <= `VDSP_RST_MASK;
			freeze_r  <= `VDSP_RST_EXTHOLD;
			err_r     <= 1'b0;
			und_r     <= 1'b0;
			nmi_r     <= 1'b0;
			inject_r  <= 16'h0;
		end else begin
			run_r     <= run_nxt;
			pc_r      <= pc_nxt;
			st_r      <= st_nxt;
			halt_st_r <= halt_st_nxt;
			mask_r    <= mask_nxt;
			freeze_r  <= freeze_nxt;
			err_r     <= err_nxt;
			und_r     <= und_nxt;
			nmi_r     <= nmi_nxt;
			inject_r  <= inject_nxt;
		end
	end

	// ---- hold request path to core arbitration
	assign hif.req       = (st_r == VDSP_HREQ) && !freeze_r;
	assign dsp_hold_req  = hif.req;
	assign dsp_hold_ack  = gate_ack;
	assign dsp_ext_wr    = (st_r == VDSP_XFER) && (inject_r[15:11] == VDSP_OP_EXTWR);
	assign dsp_ext_arg   = inject_r[10:0];
	assign dsp_irq_out_n = !(halt_st_r && mask_r);
	assign nmi_req       = nmi_r;

	// ---- axi read: one cycle to rvalid
	logic		rvalid_r, rvalid_nxt;
	logic [31:0]	rdata_r, rdata_nxt, rval;
	logic [10:0]	hr_word;
	assign hr_word       = s_axi_araddr[11:1];
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = 2'h0;
	always_comb begin
		rval = 32'h0;
		if (in_ram(s_axi_araddr))
			rval = {ram[hr_word + 11'd1], ram[hr_word]};
		else begin
			case (s_axi_araddr[11:0])
			`VDSP_OFF_LIST_STAT: rval = {31'h0, run_r};
			`VDSP_OFF_INT_STAT:  rval = {31'h0, halt_st_r};
			`VDSP_OFF_INT_MASK:  rval = {31'h0, mask_r};
			`VDSP_OFF_EXT_HOLD:  rval = {31'h0, freeze_r};
			`VDSP_OFF_NMI_STAT:  rval = {30'h0, und_r, err_r};
			`VDSP_OFF_CMD_PTR:   rval = {21'h0, pc_r};
			default:             rval = 32'h0;
			endcase
		end
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rval;
		end else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// ---- checks
	run_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start |=> run_r) else $error("run not set after pointer write");
	stop_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(run_r) |-> halt_st_r) else $error("halt status missing");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(halt_st_r && mask_r) |-> !dsp_irq_out_n) else $error("irq not low");
	viol_nmi_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_viol || rd_viol) |=> (nmi_req && err_r && !run_r))
		else $error("violation not handled");
	abort_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wreg && run_r && awaddr_r[11:0] == `VDSP_OFF_ABORT) |=> !run_r)
		else $error("abort ignored");
	freeze_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
		freeze_r |-> !dsp_hold_req) else $error("request while frozen");
	xfer_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == VDSP_XFER) |=> !dsp_hold_req ##1 !dsp_hold_req)
		else $error("no bus release");
	hold_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == VDSP_XFER && run_r) |-> $past(dsp_hold_req))
		else $error("transfer without request");
endmodule // vdsp_core_if

/* File: vdsp_arb_model.sv */
`timescale 1ns/10ps
module vdsp_arb_model (
	// clock and reset
	input	wire logic		aclk,
	input	wire logic		aresetn,
	// bench control
	input	wire logic		hold_on,
	// design side
	input	wire logic		dsp_hold_req,
	input	wire logic		dsp_hold_ack,
	input	wire logic		dsp_ext_wr,
	input	wire logic [10:0]	dsp_ext_arg,
	output	logic			ext_hold_n,
	// observations
	output	int			ack_cnt,
	output	int			err_cnt,
	output	logic [10:0]		last_arg,
	output	logic			last_wr
);
	int	held;
	logic	req_d;
	logic	ack_d;

	initial begin
		ext_hold_n = 1'b1;
		ack_cnt = 0;
		err_cnt = 0;
		held = 0;
		req_d = 1'b0;
		ack_d = 1'b0;
	end

	always @(posedge aclk) begin
		ext_hold_n <= !hold_on; // external master claims the bus
		held <= ext_hold_n ? 0 : held + 1;
		req_d <= dsp_hold_req;
		ack_d <= dsp_hold_ack;
		if (aresetn && dsp_hold_ack === 1'b1) begin
			ack_cnt <= ack_cnt + 1;
			last_arg <= dsp_ext_arg;
			// slack of five covers the pin synchroniser
			if (req_d !== 1'b1 || ack_d === 1'b1 || held > 5) err_cnt <= err_cnt + 1;
		end
		// the write strobe stands in the transfer cycle that follows the grant
		if (aresetn && ack_d === 1'b1) last_wr <= dsp_ext_wr;
		if (ack_d === 1'b1 && dsp_hold_req === 1'b1) err_cnt <= err_cnt + 1;
	end
endmodule // vdsp_arb_model

/* File: test_dsp_core_sync_interface.sv */
`timescale 1ns/10ps
`include "vdsp_regs.svh"
module test_dsp_core_sync_interface;
	localparam logic [31:0] A_PTR = 32'h0, A_STAT = 32'h4, A_ABT = 32'h8, A_EXT = 32'hC;
	localparam logic [31:0] A_INT = 32'h10, A_MSK = 32'h14, A_NMI = 32'h18, RAM = `VDSP_RAM_BASE;
	logic		aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold_on;
	logic		awready, wready, bvalid, arready, rvalid, irq_n, nmi, hreq, hack, xwr, xhn;
	logic [31:0]	awaddr, wdata, araddr, rdata, rd;
	logic [3:0]	wstrb;
	logic [1:0]	bresp, rresp;
	logic [10:0]	xarg, last_arg;
	logic		last_wr;
	int		ack_cnt, err_cnt, fails, n_compared, nmi_cnt;

	vdsp_core_if i_vdsp_core_if (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_hold_n(xhn), .dsp_hold_req(hreq), .dsp_hold_ack(hack), .dsp_ext_wr(xwr),
		.dsp_ext_arg(xarg), .dsp_irq_out_n(irq_n), .nmi_req(nmi));
	vdsp_arb_model i_vdsp_arb_model (.aclk(aclk), .aresetn(aresetn), .hold_on(hold_on),
		.dsp_hold_req(hreq), .dsp_hold_ack(hack), .dsp_ext_wr(xwr), .dsp_ext_arg(xarg),
		.ext_hold_n(xhn), .ack_cnt(ack_cnt), .err_cnt(err_cnt), .last_arg(last_arg),
		.last_wr(last_wr));

	initial aclk = 1'b0;
	always #12.5 aclk = !aclk;
	always @(posedge aclk) if (nmi === 1'b1) nmi_cnt++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	// leading edge keeps back-to-back calls from assigning a signal twice in one step
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int t = 0;
		bit go = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (go && t < 100) begin
			@(posedge aclk);
			t++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				go = 0;
			end
		end
		if (go) chk({31'h0, go}, 32'h0);
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d);
		int t = 0;
		bit go = 1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (go && t < 100) begin
			@(posedge aclk);
			t++;
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				rready <= 1'b0;
				go = 0;
			end
		end
		if (go) chk({31'h0, go}, 32'h0);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a, rd);
		chk(rd & m, e);
	endtask

	task automatic idle();
		int t = 0;
		do begin
			axi_rd(A_STAT, rd);
			t++;
		end while (rd[0] !== 1'b0 && t < 40);
		chk({31'h0, rd[0]}, 32'h0);
	endtask

	task automatic t_basic();
		rdc(A_STAT, 32'h1, 32'h0);
		rdc(A_MSK, 32'h1, 32'h0);
		rdc(A_NMI, 32'h3, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		wr(RAM + 32'h20, 32'h0800_0000, 4'hF);
		wr(RAM + 32'h20, 32'h00EE_0000, 4'h4);
		rdc(RAM + 32'h20, 32'hFFFF_FFFF, 32'h08EE_0000);
		wr(RAM + 32'h40, 32'h0000_F800, 4'hF);
		wr(RAM + 32'h60, 32'h0800_1855, 4'hF);
		wr(RAM + 32'h80, 32'h0800_2123, 4'hF);
		wr(A_MSK, 32'h1, 4'hF);
		wr(A_PTR, 32'h10, 4'hF);
		idle();
		rdc(A_INT, 32'h1, 32'h1);
		chk({31'h0, irq_n}, 32'h0);
		wr(A_MSK, 32'h0, 4'hF);
		chk({31'h0, irq_n}, 32'h1);
		wr(A_INT, 32'h1, 4'hF);
		rdc(A_INT, 32'h1, 32'h0);
		wr(RAM + 32'hA0, 32'h0000_1000, 4'hF);
		wr(A_PTR, 32'h50, 4'hF);
		idle();
		rdc(A_INT, 32'h1, 32'h1);
		wr(A_INT, 32'h1, 4'hF);
		$display("test basic done");
	endtask

	task automatic t_reserved();
		int n0 = nmi_cnt;
		wr(A_MSK, 32'h1, 4'hF);
		wr(A_PTR, 32'h20, 4'hF);
		idle();
		rdc(A_NMI, 32'h3, 32'h2);
		chk(32'(nmi_cnt - n0), 32'h1);
		rdc(A_MSK, 32'h1, 32'h1);
		rdc(A_EXT, 32'h1, 32'h0);
		wr(A_NMI, 32'h3, 4'hF);
		wr(A_MSK, 32'h0, 4'hF);
		$display("test reserved done");
	endtask

	task automatic t_freeze_abort();
		int a0 = ack_cnt;
		wr(A_EXT, 32'h1, 4'hF);
		wr(A_PTR, 32'h30, 4'hF);
		rdc(A_STAT, 32'h1, 32'h1);
		rdc(A_STAT, 32'h1, 32'h1);
		chk(32'(ack_cnt - a0), 32'h0);
		wr(A_EXT, 32'h0, 4'hF);
		idle();
		chk(32'(ack_cnt - a0), 32'h1);
		chk({21'h0, last_arg}, 32'h55);
		chk({31'h0, last_wr}, 32'h0);
		wr(A_INT, 32'h1, 4'hF);
		wr(A_EXT, 32'h1, 4'hF);
		wr(A_PTR, 32'h30, 4'hF);
		wr(A_ABT, 32'h0, 4'hF);
		rdc(A_STAT, 32'h1, 32'h0);
		rdc(A_INT, 32'h1, 32'h1);
		rdc(A_NMI, 32'h3, 32'h0);
		wr(A_EXT, 32'h0, 4'hF);
		rdc(A_STAT, 32'h1, 32'h0);
		chk(32'(ack_cnt - a0), 32'h1);
		$display("test freeze abort done");
	endtask

	task automatic t_violation();
		int n0 = nmi_cnt;
		wr(A_EXT, 32'h1, 4'hF);
		wr(A_PTR, 32'h30, 4'hF);
		axi_rd(RAM + 32'h60, rd);
		idle();
		rdc(A_NMI, 32'h3, 32'h1);
		chk(32'(nmi_cnt - n0), 32'h1);
		wr(A_NMI, 32'h3, 4'hF);
		wr(A_PTR, 32'h30, 4'hF);
		wr(RAM + 32'h60, 32'h0, 4'hF);
		rdc(A_NMI, 32'h3, 32'h1);
		wr(A_EXT, 32'h0, 4'hF);
		wr(A_NMI, 32'h3, 4'hF);
		rdc(RAM + 32'h60, 32'hFFFF_FFFF, 32'h0800_1855);
		$display("test violation done");
	endtask

	task automatic t_ext_hold();
		int a0 = ack_cnt;
		hold_on <= 1'b1;
		// let the pin pass its three-flop synchroniser first
		repeat (8) @(posedge aclk);
		wr(A_PTR, 32'h40, 4'hF);
		rdc(A_STAT, 32'h1, 32'h1);
		chk(32'(ack_cnt - a0), 32'h0);
		hold_on <= 1'b0;
		idle();
		chk(32'(ack_cnt - a0), 32'h1);
		chk({21'h0, last_arg}, 32'h123);
		chk({31'h0, last_wr}, 32'h1);
		chk(32'(err_cnt), 32'h0);
		$display("test ext hold done");
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hold_on} = '0;
		{awaddr, wdata, araddr, wstrb} = '0;
		{fails, n_compared, nmi_cnt} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_basic();
		t_reserved();
		t_freeze_abort();
		t_violation();
		t_ext_hold();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		print_verdict();
	end
endmodule // test_dsp_core_sync_interface
